// file: bench/dgd_host_model.sv
/*
   Host controller model: masters the register port, loads configuration,
   sets edge triggers by group number and services pending edges.
   Assumes a slave that never waits and answers reads one cycle later.
*/
`timescale 1ns/1ns
`default_nettype none

module dgd_host_model (
   // Clock
   input  wire logic                      clk_i,
   // Register port
   output logic [dgd_pkg::ADR_W-1:0]      addr_o,
   output logic [dgd_pkg::DAT_W-1:0]      wdata_o,
   output logic                           we_o,
   output logic                           re_o,
   input  wire logic [dgd_pkg::DAT_W-1:0] rdata_i
);
   logic [15:0] edge_sh;

   initial begin
      addr_o  = '0;
      wdata_o = '0;
      we_o    = 1'b0;
      re_o    = 1'b0;
      edge_sh = '0;
   end

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr_o  <= a;
      wdata_o <= d;
      we_o    <= 1'b1;
      @(posedge clk_i);
      we_o    <= 1'b0;
      // Released bus shows no stale value
      addr_o  <= ~a;
      wdata_o <= ~d;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_i);
      addr_o <= a;
      re_o   <= 1'b1;
      @(posedge clk_i);
      re_o   <= 1'b0;
      addr_o <= ~a;
      #1 d = rdata_i;
   endtask : rd

   // Triggers addressed by group number, pair 2g and 2g+1
   task automatic set_edge(input int g, input logic r, input logic f);
      edge_sh[g]     = r;
      edge_sh[g + 8] = f;
      wr(dgd_pkg::OFF_EDGE, {16'h0000, edge_sh});
   endtask : set_edge

   // Service pending edges by writing ones
   task automatic service(input logic [15:0] bits);
      wr(dgd_pkg::OFF_PEND, {16'h0000, bits});
   endtask : service
endmodule : dgd_host_model
`default_nettype wire

// file: bench/tb_dgd_top.sv
/*
   Self-checking bench for the input diagnostics block, short delays.
   Assumes the host model drives the register port and the bench the field side.
*/
`timescale 1ns/1ns
`default_nettype none

module tb_dgd_top;
   localparam int unsigned HOLD = 20;
   logic        clk_i, srst_i, we, re, load_ok, ext_aux, int_aux, fuse, lamp, irq;
   logic [7:0]  addr;
   logic [31:0] wdata, rdata;
   logic [15:0] raw, wbrk, inval, cur;
   logic [1:0]  smiss, sshort, supo;
   int          mismatches, n_compared;

   dgd_host_model host_u (.clk_i(clk_i), .addr_o(addr), .wdata_o(wdata), .we_o(we),
      .re_o(re), .rdata_i(rdata));

   dgd_top #(.DLY_CYC0(2), .DLY_CYC1(3), .DLY_CYC2(4), .DLY_CYC3(5), .DLY_CYC4(6),
      .HOLD_CYC(HOLD)) dut_u (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr),
      .wdata_i(wdata), .we_i(we), .re_i(re), .rdata_o(rdata), .raw_in_i(raw),
      .wire_break_i(wbrk), .load_ok_i(load_ok), .sensor_missing_i(smiss),
      .sensor_short_i(sshort), .ext_aux_missing_i(ext_aux), .int_aux_missing_i(int_aux),
      .fuse_blown_i(fuse), .in_value_o(inval), .sensor_supply_out_o(supo),
      .group_fault_lamp_o(lamp), .irq_o(irq));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] v;
      host_u.rd(a, v);
      chk(v, e);
   endtask : rdc

   task automatic cw(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : cw

   task automatic end_sim;
      if (mismatches == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : end_sim

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   initial begin
      #100000;
      mismatches++;
      end_sim();
   end

   initial begin
      srst_i     = 1'b1;
      load_ok    = 1'b1;
      ext_aux    = 1'b0;
      int_aux    = 1'b0;
      fuse       = 1'b0;
      raw        = 16'h0000;
      wbrk       = 16'h0000;
      smiss      = 2'h0;
      sshort     = 2'h0;
      cur        = 16'h0000;
      mismatches = 0;
      n_compared = 0;
      repeat (4) @(posedge clk_i);
      srst_i <= 1'b0;
      cw(2);
      // Reset state and an unmapped place
      rdc(dgd_pkg::OFF_CFG, 32'h00000040);
      rdc(dgd_pkg::OFF_EDGE, 32'h0);
      rdc(dgd_pkg::OFF_MASK, 32'h0);
      rdc(dgd_pkg::OFF_DIAG, 32'h0);
      host_u.wr(8'h1C, 32'hFFFFFFFF);
      rdc(8'h1C, 32'h0);
      rdc(dgd_pkg::OFF_CFG, 32'h00000040);
      chk(32'(lamp), 32'h0);
      chk(32'(supo), 32'h3);
      // Every delay: a glitch one short is dropped, a steady level passes
      for (int s = 0; s < 5; s++) begin
         host_u.wr(dgd_pkg::OFF_CFG, 32'(s) << 5);
         @(posedge clk_i) raw <= ~cur ^ 16'h5A5A;
         repeat (s + 1) @(posedge clk_i);
         raw <= cur;
         cw(s + 5);
         chk(32'(inval), 32'(cur));
         @(posedge clk_i) raw <= ~cur ^ 16'h5A5A;
         cur = ~cur ^ 16'h5A5A;
         cw(s + 5);
         chk(32'(inval), 32'(cur));
      end
      // Short supply dip, then a real loss
      @(posedge clk_i) load_ok <= 1'b0;
      cw(HOLD - 10);
      chk(32'(inval), 32'(cur));
      chk(32'(lamp), 32'h1);
      rdc(dgd_pkg::OFF_DIAG, 32'h00008000);
      @(posedge clk_i) load_ok <= 1'b1;
      cw(4);
      chk(32'(inval), 32'(cur));
      chk(32'(lamp), 32'h0);
      @(posedge clk_i) load_ok <= 1'b0;
      cw(HOLD + 4);
      chk(32'(inval), 32'h0);
      rdc(dgd_pkg::OFF_INPUT, 32'h0);
      @(posedge clk_i) load_ok <= 1'b1;
      cw(4);
      rdc(dgd_pkg::OFF_INPUT, 32'(cur));
      // Always-on faults with diagnosis disabled
      host_u.wr(dgd_pkg::OFF_CFG, 32'h0);
      for (int k = 0; k < 3; k++) begin
         @(posedge clk_i) ext_aux <= (k == 0);
         int_aux <= (k == 1);
         fuse    <= (k == 2);
         cw(3);
         rdc(dgd_pkg::OFF_DIAG, 32'h00000400 << k);
         chk(32'(lamp), 32'h1);
         @(posedge clk_i) ext_aux <= 1'b0;
         int_aux <= 1'b0;
         fuse    <= 1'b0;
         cw(4);
         chk(32'(lamp), 32'h0);
      end
      // Configurable faults follow their enables and groups
      @(posedge clk_i) wbrk <= 16'h0004;
      smiss <= 2'b01;
      cw(3);
      rdc(dgd_pkg::OFF_DIAG, 32'h0);
      chk(32'(lamp), 32'h0);
      host_u.wr(dgd_pkg::OFF_CFG, 32'h0000001C);
      cw(3);
      rdc(dgd_pkg::OFF_DIAG, 32'h00000009);
      host_u.wr(dgd_pkg::OFF_CFG, 32'h00000014);
      @(posedge clk_i) smiss <= 2'b10;
      cw(3);
      rdc(dgd_pkg::OFF_DIAG, 32'h00000008);
      @(posedge clk_i) wbrk <= 16'h0000;
      smiss  <= 2'b00;
      sshort <= 2'b10;
      cw(4);
      chk(32'(lamp), 32'h1);
      chk(32'(supo), 32'h1);
      @(posedge clk_i) sshort <= 2'b00;
      cw(4);
      chk(32'(lamp), 32'h0);
      // Diagnostic interrupt on appearing and on clearing
      host_u.wr(dgd_pkg::OFF_CFG, 32'h00000001);
      host_u.wr(dgd_pkg::OFF_MASK, 32'h1);
      host_u.wr(dgd_pkg::OFF_STAT, 32'h3);
      @(posedge clk_i) fuse <= 1'b1;
      cw(4);
      chk(32'(irq), 32'h1);
      rdc(dgd_pkg::OFF_STAT, 32'h1);
      host_u.wr(dgd_pkg::OFF_STAT, 32'h1);
      cw(2);
      chk(32'(irq), 32'h0);
      @(posedge clk_i) fuse <= 1'b0;
      cw(4);
      chk(32'(irq), 32'h1);
      host_u.wr(dgd_pkg::OFF_MASK, 32'h0);
      cw(1);
      chk(32'(irq), 32'h0);
      // Edge triggers, one group at a time
      host_u.wr(dgd_pkg::OFF_CFG, 32'h00000002);
      host_u.wr(dgd_pkg::OFF_MASK, 32'h2);
      host_u.wr(dgd_pkg::OFF_STAT, 32'h3);
      @(posedge clk_i) raw <= 16'h0;
      cw(6);
      host_u.service(16'hFFFF);
      for (int g = 0; g < 8; g++) begin
         host_u.set_edge(g, 1'b1, 1'b0);
         @(posedge clk_i) raw <= 16'h0002 << (2 * g);
         cw(6);
         rdc(dgd_pkg::OFF_PEND, 32'h00000002 << (2 * g));
         host_u.service(16'h0002 << (2 * g));
      end
      chk(32'(irq), 32'h1);
      host_u.set_edge(0, 1'b0, 1'b1);
      @(posedge clk_i) raw <= 16'h0001;
      cw(6);
      rdc(dgd_pkg::OFF_PEND, 32'h0);
      @(posedge clk_i) raw <= 16'h0000;
      cw(6);
      rdc(dgd_pkg::OFF_PEND, 32'h1);
      // Second edge while the first is still pending
      @(posedge clk_i) raw <= 16'h0001;
      cw(6);
      @(posedge clk_i) raw <= 16'h0000;
      cw(6);
      rdc(dgd_pkg::OFF_DIAG, 32'h00004000);
      rdc(dgd_pkg::OFF_PEND, 32'h1);
      chk(32'(lamp), 32'h1);
      host_u.service(16'h0001);
      rdc(dgd_pkg::OFF_PEND, 32'h0);
      // Illegal delay keeps the old one and flags a parameter fault
      host_u.wr(dgd_pkg::OFF_CFG, 32'h000000A0);
      cw(3);
      rdc(dgd_pkg::OFF_CFG, 32'h0);
      rdc(dgd_pkg::OFF_DIAG, 32'h00006000);
      host_u.wr(dgd_pkg::OFF_CFG, 32'h0);
      cw(3);
      rdc(dgd_pkg::OFF_DIAG, 32'h0);
      // Reset in mid-run drops the loaded setup
      host_u.wr(dgd_pkg::OFF_MASK, 32'h3);
      cw(1);
      chk(32'(irq), 32'h1);
      @(posedge clk_i) srst_i <= 1'b1;
      cw(2);
      @(posedge clk_i) srst_i <= 1'b0;
      cw(1);
      chk(32'(irq), 32'h0);
      rdc(dgd_pkg::OFF_CFG, 32'h00000040);
      rdc(dgd_pkg::OFF_EDGE, 32'h0);
      rdc(dgd_pkg::OFF_MASK, 32'h0);
      rdc(dgd_pkg::OFF_STAT, 32'h0);
      end_sim();
   end
endmodule : tb_dgd_top
`default_nettype wire

// file: common/dgd_pkg.sv
/*
   Package for the dual-group input diagnostics block: register map, field layouts,
   reset values and timing counts.
   Assumes a 100 MHz clock and a 32-bit plain register port with byte offsets.
*/
package dgd_pkg;

   // Clock and timing
   localparam int unsigned CLK_MHZ  = 100;
   localparam int unsigned DLY0_US  = 100;
   localparam int unsigned DLY1_US  = 500;
   localparam int unsigned DLY2_US  = 3000;
   localparam int unsigned DLY3_US  = 15000;
   localparam int unsigned DLY4_US  = 20000;
   localparam int unsigned DLY0_CYC = DLY0_US * CLK_MHZ;
   localparam int unsigned DLY1_CYC = DLY1_US * CLK_MHZ;
   localparam int unsigned DLY2_CYC = DLY2_US * CLK_MHZ;
   localparam int unsigned DLY3_CYC = DLY3_US * CLK_MHZ;
   localparam int unsigned DLY4_CYC = DLY4_US * CLK_MHZ;
   localparam int unsigned HOLD_MS  = 30;
   localparam int unsigned HOLD_CYC = HOLD_MS * 1000 * CLK_MHZ;
   localparam int unsigned CNT_W    = 22;

   // Sizes
   localparam int unsigned NCH   = 16;
   localparam int unsigned NGRP  = 8;
   localparam int unsigned NSUP  = 2;
   localparam int unsigned ADR_W = 8;
   localparam int unsigned DAT_W = 32;

   // Register byte offsets
   localparam logic [7:0] OFF_CFG   = 8'h00;
   localparam logic [7:0] OFF_EDGE  = 8'h04;
   localparam logic [7:0] OFF_INPUT = 8'h08;
   localparam logic [7:0] OFF_DIAG  = 8'h0C;
   localparam logic [7:0] OFF_PEND  = 8'h10;
   localparam logic [7:0] OFF_STAT  = 8'h14;
   localparam logic [7:0] OFF_MASK  = 8'h18;

   // Configuration word, bits 7:0 of the configuration register
   typedef struct packed {
      logic [2:0] delay_sel;
      logic       wire_diag_en;
      logic [1:0] supply_diag_en;
      logic       hw_irq_en;
      logic       diag_irq_en;
   } dgd_cfg_t;
   localparam int unsigned CFG_W       = 8;
   localparam logic [2:0]  DLY_SEL_DEF = 3'h2;
   localparam logic [2:0]  DLY_SEL_MAX = 3'h4;
   localparam dgd_cfg_t    CFG_RST     = '{delay_sel: DLY_SEL_DEF, default: '0};

   // Edge trigger word: rise enables in 7:0, fall enables in 15:8
   typedef struct packed {
      logic [7:0] fall;
      logic [7:0] rise;
   } dgd_edge_t;
   localparam int unsigned EDGE_W = 16;

   // Diagnostic data word, bits 15:0 of the diagnostic register
   typedef struct packed {
      logic       load_fail;
      logic       hw_lost;
      logic       param_err;
      logic       fuse;
      logic       int_aux;
      logic       ext_aux;
      logic [7:0] wire_break;
      logic [1:0] supply_missing;
   } dgd_diag_t;
   localparam int unsigned DIAG_W = 16;

   // Interrupt status and mask layout
   localparam int unsigned IRQ_W      = 2;
   localparam int unsigned IRQ_DIAG_B = 0;
   localparam int unsigned IRQ_HW_B   = 1;

endpackage : dgd_pkg

// file: verilog/dgd_filter.sv
/*
   Single-channel input delay filter: the output follows the raw level once it has
   stayed constant for limit_i cycles.
   Assumes raw_i is synchronous to clk_i and limit_i is at least one.
*/
`timescale 1ns/1ns
`default_nettype none

module dgd_filter #(
   parameter int unsigned CNT_W = 22
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             srst_i,
   // Channel
   input  wire logic             raw_i,
   input  wire logic [CNT_W-1:0] limit_i,
   output logic                  value_o
);

   logic [CNT_W-1:0] cnt_q;
   logic             value_q;

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         cnt_q   <= '0;
         value_q <= 1'b0;
      end else if (raw_i == value_q) begin
         cnt_q <= '0;
      end else if ((cnt_q + CNT_W'(1)) >= limit_i) begin
         value_q <= raw_i;
         cnt_q   <= '0;
      end else begin
         cnt_q <= cnt_q + CNT_W'(1);
      end
   end

   assign value_o = value_q;

   property p_stable_before_update;
      @(posedge clk_i) disable iff (srst_i)
      $changed(value_q) |-> (($past(cnt_q) + CNT_W'(1)) >= $past(limit_i));
   endproperty
   a_stable_before_update: assert property (p_stable_before_update)
      else $error("filter output changed before the delay elapsed");

endmodule : dgd_filter

`default_nettype wire

// file: verilog/dgd_top.sv
/*
   Diagnostics, input filtering and configuration for a 16-channel digital input
   block with two sensor-supply groups and eight edge-interrupt channel pairs.
   Assumes all inputs are synchronous to clk_i and a plain register port that never
   waits; the host services edge interrupts by clearing pending bits.
*/
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

module dgd_top #(
   parameter int unsigned CNT_W    = dgd_pkg::CNT_W,
   parameter int unsigned DLY_CYC0 = dgd_pkg::DLY0_CYC,
   parameter int unsigned DLY_CYC1 = dgd_pkg::DLY1_CYC,
   parameter int unsigned DLY_CYC2 = dgd_pkg::DLY2_CYC,
   parameter int unsigned DLY_CYC3 = dgd_pkg::DLY3_CYC,
   parameter int unsigned DLY_CYC4 = dgd_pkg::DLY4_CYC,
   parameter int unsigned HOLD_CYC = dgd_pkg::HOLD_CYC
) (
   // Clock and reset
   input  wire logic                       clk_i,
   input  wire logic                       srst_i,
   // Register port
   input  wire logic [dgd_pkg::ADR_W-1:0]  addr_i,
   input  wire logic [dgd_pkg::DAT_W-1:0]  wdata_i,
   input  wire logic                       we_i,
   input  wire logic                       re_i,
   output logic [dgd_pkg::DAT_W-1:0]       rdata_o,
   // Field inputs and supply monitors
   input  wire logic [dgd_pkg::NCH-1:0]    raw_in_i,
   input  wire logic [dgd_pkg::NCH-1:0]    wire_break_i,
   input  wire logic                       load_ok_i,
   input  wire logic [dgd_pkg::NSUP-1:0]   sensor_missing_i,
   input  wire logic [dgd_pkg::NSUP-1:0]   sensor_short_i,
   input  wire logic                       ext_aux_missing_i,
   input  wire logic                       int_aux_missing_i,
   input  wire logic                       fuse_blown_i,
   // Outputs
   output logic [dgd_pkg::NCH-1:0]         in_value_o,
   output logic [dgd_pkg::NSUP-1:0]        sensor_supply_out_o,
   output logic                            group_fault_lamp_o,
   output logic                            irq_o
);

   localparam int unsigned NCH  = dgd_pkg::NCH;
   localparam int unsigned NGRP = dgd_pkg::NGRP;

   dgd_pkg::dgd_cfg_t            cfg_q;
   dgd_pkg::dgd_cfg_t            cfg_w;
   dgd_pkg::dgd_edge_t           edge_q;
   dgd_pkg::dgd_diag_t           diag_d;
   dgd_pkg::dgd_diag_t           diag_q;
   logic [NCH-1:0]               filt;
   logic [NCH-1:0]               filt_prev_q;
   logic [NCH-1:0]               evt;
   logic [NCH-1:0]               busy;
   logic [NCH-1:0]               accept;
   logic [NCH-1:0]               pend_q;
   logic [NCH-1:0]               pend_clr;
   logic [NCH-1:0]               in_value_q;
   logic [NGRP-1:0]              wire_grp;
   logic [dgd_pkg::IRQ_W-1:0]    stat_q;
   logic [dgd_pkg::IRQ_W-1:0]    stat_set;
   logic [dgd_pkg::IRQ_W-1:0]    stat_clr;
   logic [dgd_pkg::IRQ_W-1:0]    mask_q;
   logic [CNT_W-1:0]             limit;
   logic [CNT_W-1:0]             hold_cnt_q;
   logic [dgd_pkg::DAT_W-1:0]    rdata_q;
   logic [dgd_pkg::NSUP-1:0]     supply_q;
   logic                         zero_q;
   logic                         lamp_q;
   logic                         param_err_q;
   logic                         hw_lost_q;
   logic                         lost;
   logic                         sel_ok;
   logic                         wr_cfg;
   logic                         wr_edge;
   logic                         wr_pend;
   logic                         wr_stat;
   logic                         wr_mask;

   // Write decode
   assign wr_cfg  = we_i && (addr_i == dgd_pkg::OFF_CFG);
   assign wr_edge = we_i && (addr_i == dgd_pkg::OFF_EDGE);
   assign wr_pend = we_i && (addr_i == dgd_pkg::OFF_PEND);
   assign wr_stat = we_i && (addr_i == dgd_pkg::OFF_STAT);
   assign wr_mask = we_i && (addr_i == dgd_pkg::OFF_MASK);
   assign cfg_w   = dgd_pkg::dgd_cfg_t'(wdata_i[dgd_pkg::CFG_W-1:0]);
   assign sel_ok  = (cfg_w.delay_sel <= dgd_pkg::DLY_SEL_MAX);

   // Configuration; an illegal delay keeps the old one and flags the error
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         cfg_q <= dgd_pkg::CFG_RST;
      end else if (wr_cfg) begin
         cfg_q           <= cfg_w;
         cfg_q.delay_sel <= sel_ok ? cfg_w.delay_sel : cfg_q.delay_sel;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         edge_q <= '0;
      end else if (wr_edge) begin
         edge_q <= dgd_pkg::dgd_edge_t'(wdata_i[dgd_pkg::EDGE_W-1:0]);
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         param_err_q <= 1'b0;
      end else if (wr_cfg) begin
         param_err_q <= !sel_ok;
      end
   end

   // Lost interrupt stays until parameters with a legal delay are loaded; a new loss wins
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         hw_lost_q <= 1'b0;
      end else if (lost) begin
         hw_lost_q <= 1'b1;
      end else if (wr_cfg && sel_ok) begin
         hw_lost_q <= 1'b0;
      end
   end

   // Delay selection
   always_comb begin
      unique case (cfg_q.delay_sel)
         3'h0:    limit = CNT_W'(DLY_CYC0);
         3'h1:    limit = CNT_W'(DLY_CYC1);
         3'h2:    limit = CNT_W'(DLY_CYC2);
         3'h3:    limit = CNT_W'(DLY_CYC3);
         default: limit = CNT_W'(DLY_CYC4);
      endcase
   end

   // Per-channel filter and edge detection
   for (genvar i = 0; i < NCH; i++) begin : g_ch
      dgd_filter #(
         .CNT_W   (CNT_W)
      ) u_filter (
         .clk_i   (clk_i),
         .srst_i  (srst_i),
         .raw_i   (raw_in_i[i]),
         .limit_i (limit),
         .value_o (filt[i])
      );
      assign evt[i] = cfg_q.hw_irq_en &&
                      ((edge_q.rise[i/2] && filt[i] && !filt_prev_q[i]) ||
                       (edge_q.fall[i/2] && !filt[i] && filt_prev_q[i]));
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         filt_prev_q <= '0;
      end else begin
         filt_prev_q <= filt;
      end
   end

   // Pending edge interrupts; a clear and a new event together leave it pending
   assign pend_clr = wr_pend ? wdata_i[NCH-1:0] : '0;
   assign busy     = pend_q & ~pend_clr;
   assign accept   = evt & ~busy;
   assign lost     = |(evt & busy);

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         pend_q <= '0;
      end else begin
         pend_q <= busy | accept;
      end
   end

   // Load supply hold-off
   always_ff @(posedge clk_i) begin
      if (srst_i || load_ok_i) begin
         hold_cnt_q <= '0;
         zero_q     <= 1'b0;
      end else if (hold_cnt_q == CNT_W'(HOLD_CYC - 1)) begin
         zero_q <= 1'b1;
      end else begin
         hold_cnt_q <= hold_cnt_q + CNT_W'(1);
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         in_value_q <= '0;
      end else begin
         in_value_q <= zero_q ? '0 : filt;
      end
   end

   // Diagnostic conditions
   always_comb begin
      for (int g = 0; g < NGRP; g++) begin
         wire_grp[g] = |wire_break_i[2*g +: 2];
      end
      diag_d                = '0;
      diag_d.supply_missing = sensor_missing_i & cfg_q.supply_diag_en;
      diag_d.wire_break     = wire_grp & {NGRP{cfg_q.wire_diag_en}};
      diag_d.ext_aux        = ext_aux_missing_i;
      diag_d.int_aux        = int_aux_missing_i;
      diag_d.fuse           = fuse_blown_i;
      diag_d.param_err      = param_err_q;
      diag_d.hw_lost        = hw_lost_q;
      diag_d.load_fail      = !load_ok_i;
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         diag_q   <= '0;
         lamp_q   <= 1'b0;
         supply_q <= '0;
      end else begin
         diag_q   <= diag_d;
         lamp_q   <= (|diag_d) || (|sensor_short_i);
         supply_q <= ~sensor_short_i;
      end
   end

   // Interrupt status, set wins over write-one-to-clear
   assign stat_set[dgd_pkg::IRQ_DIAG_B] = cfg_q.diag_irq_en && (diag_d != diag_q);
   assign stat_set[dgd_pkg::IRQ_HW_B]   = |accept;
   assign stat_clr = wr_stat ? wdata_i[dgd_pkg::IRQ_W-1:0] : '0;

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         stat_q <= '0;
         mask_q <= '0;
      end else begin
         stat_q <= (stat_q & ~stat_clr) | stat_set;
         if (wr_mask) begin
            mask_q <= wdata_i[dgd_pkg::IRQ_W-1:0];
         end
      end
   end

   // Read data, valid only in the cycle after the strobe
   always_ff @(posedge clk_i) begin
      if (srst_i || !re_i) begin
         rdata_q <= '0;
      end else begin
         unique case (addr_i)
            dgd_pkg::OFF_CFG:   rdata_q <= {24'h000000, cfg_q};
            dgd_pkg::OFF_EDGE:  rdata_q <= {16'h0000, edge_q};
            dgd_pkg::OFF_INPUT: rdata_q <= {16'h0000, in_value_q};
            dgd_pkg::OFF_DIAG:  rdata_q <= {16'h0000, diag_q};
            dgd_pkg::OFF_PEND:  rdata_q <= {16'h0000, pend_q};
            dgd_pkg::OFF_STAT:  rdata_q <= {30'h0, stat_q};
            dgd_pkg::OFF_MASK:  rdata_q <= {30'h0, mask_q};
            default:            rdata_q <= '0;
         endcase
      end
   end

   assign rdata_o             = rdata_q;
   assign in_value_o          = in_value_q;
   assign sensor_supply_out_o = supply_q;
   assign group_fault_lamp_o  = lamp_q;
   assign irq_o               = |(stat_q & mask_q);

   property p_cfg_gate;
      @(posedge clk_i) disable iff (srst_i)
      (cfg_q.supply_diag_en == 2'h0 && !cfg_q.wire_diag_en) |->
         (diag_d.supply_missing == 2'h0 && diag_d.wire_break == 8'h00);
   endproperty
   a_cfg_gate: assert property (p_cfg_gate)
      else $error("configurable diagnosis reported while disabled");

   property p_fuse_always;
      @(posedge clk_i) disable iff (srst_i)
      fuse_blown_i |=> diag_q.fuse && group_fault_lamp_o;
   endproperty
   a_fuse_always: assert property (p_fuse_always)
      else $error("fuse fault not reported");

   property p_diag_irq;
      @(posedge clk_i) disable iff (srst_i)
      (cfg_q.diag_irq_en && (diag_d != diag_q)) |=> stat_q[0];
   endproperty
   a_diag_irq: assert property (p_diag_irq)
      else $error("diagnostic change did not set interrupt status");

   property p_lamp_off;
      @(posedge clk_i) disable iff (srst_i)
      (diag_d == 16'h0000 && sensor_short_i == 2'h0) |=> !group_fault_lamp_o;
   endproperty
   a_lamp_off: assert property (p_lamp_off)
      else $error("fault lamp lit with no fault present");

   property p_short_lamp;
      @(posedge clk_i) disable iff (srst_i)
      (|sensor_short_i) |=> group_fault_lamp_o;
   endproperty
   a_short_lamp: assert property (p_short_lamp)
      else $error("sensor short did not light the lamp");

   property p_delay_legal;
      @(posedge clk_i) disable iff (srst_i)
      cfg_q.delay_sel <= 3'h4;
   endproperty
   a_delay_legal: assert property (p_delay_legal)
      else $error("illegal delay selection stored");

   property p_zero_out;
      @(posedge clk_i) disable iff (srst_i)
      zero_q |=> (in_value_o == 16'h0000);
   endproperty
   a_zero_out: assert property (p_zero_out)
      else $error("inputs not forced to zero after supply loss");

   property p_hold_time;
      @(posedge clk_i) disable iff (srst_i)
      $rose(zero_q) |-> ($past(hold_cnt_q) == CNT_W'(HOLD_CYC - 1)) && !$past(load_ok_i);
   endproperty
   a_hold_time: assert property (p_hold_time)
      else $error("inputs zeroed before the hold time");

   property p_pend_kept;
      @(posedge clk_i) disable iff (srst_i)
      (busy != 16'h0000) |=> ((pend_q & $past(busy)) == $past(busy));
   endproperty
   a_pend_kept: assert property (p_pend_kept)
      else $error("pending edge interrupt dropped without service");

   property p_lost_flag;
      @(posedge clk_i) disable iff (srst_i)
      lost |=> hw_lost_q ##1 diag_q.hw_lost;
   endproperty
   a_lost_flag: assert property (p_lost_flag)
      else $error("lost interrupt not flagged");

endmodule : dgd_top

`default_nettype wire
